// ### sbh_bit_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "sbh_consts.vh"
module sbh_bit_engine (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // quarter-period enable
  input wire tick,
  // bit command
  input wire cmd_valid,
  input wire [1:0] cmd,
  input wire bit_tx,
  output reg busy,
  output reg done,
  output reg bit_rx,
  // line
  input wire sda_level,
  output reg scl_drive,
  output reg sda_drive
);
  reg [1:0] phase;
  reg [1:0] cur_cmd;
  reg cur_bit;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      bit_rx <= 1'b0;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      phase <= 2'd0;
      cur_cmd <= 2'd0;
      cur_bit <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (cmd_valid)
        begin
          busy <= 1'b1;
          phase <= 2'd0;
          cur_cmd <= cmd;
          cur_bit <= bit_tx;
        end
      end
      else if (tick)
      begin
        phase <= phase + 2'd1;
        case (phase)
          2'd0:
          begin
            scl_drive <= 1'b1;
            case (cur_cmd)
              `SBH_CMD_START: sda_drive <= 1'b0;
              `SBH_CMD_STOP: sda_drive <= 1'b1;
              `SBH_CMD_WRITE: sda_drive <= ~cur_bit;
              default: sda_drive <= 1'b0;
            endcase
          end
          2'd1: scl_drive <= 1'b0;
          2'd2:
          begin
            if (cur_cmd == `SBH_CMD_START)
              sda_drive <= 1'b1;
            else if (cur_cmd == `SBH_CMD_STOP)
              sda_drive <= 1'b0;
            bit_rx <= sda_level;
          end
          default:
          begin
            if (cur_cmd != `SBH_CMD_STOP)
              scl_drive <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // sbh_bit_engine
`default_nettype wire

// ### sbh_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbh_checker_sva (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt and two-wire bus
  input wire logic irq,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  wire logic [7:0] idx = paddr[9:2];
  wire logic ok_addr = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && idx >= 8'hb0 && idx <= 8'hb5;
  logic [8:0] idle_cnt;
  logic [1:0] mask;
  // bus idle time and mirrored mask
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      idle_cnt <= 9'h000;
      mask <= 2'h0;
    end
    else
    begin
      idle_cnt <= (scl_oe || sda_oe) ? 9'h000 : idle_cnt + {8'h00, idle_cnt != 9'h1ff};
      if (acc && pwrite && paddr == 12'h2d4)
        mask <= pwdata[1:0];
    end
  chk_apb_answer:
    assert property (psel && !penable |=> pready) else $error("no answer");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  chk_map_error:
    assert property (acc |-> pslverr == !ok_addr) else $error("pslverr wrong");
  chk_read_data:
    assert property (acc |-> prdata[31:8] == 24'h0 && (ok_addr && !pwrite || prdata[7:0] == 8'h00))
      else $error("prdata wrong");
  chk_launch_start:
    assert property (acc && pwrite && paddr == 12'h2c8 && idle_cnt == 9'h1ff
      |-> ##[1:400] sda_oe && !scl_oe) else $error("no start");
  chk_sda_steady:
    assert property ($fell(scl_oe) |=> $stable(sda_oe) [*8]) else $error("sda moved");
  chk_reset_idle:
    assert property (disable iff (1'b0) !presetn |-> !scl_oe && !sda_oe && !irq && !pready)
      else $error("reset state");
  chk_od_zero:
    assert property (!scl_o && !sda_o) else $error("drive value");
  chk_irq_clear:
    assert property (acc && !pwrite && paddr == 12'h2d0 && (prdata[1:0] & mask) != 2'h0
      |-> irq ##2 !irq) else $error("irq wrong");
  cov_launch: cover property (acc && pwrite && paddr == 12'h2c8);
  cov_slverr: cover property (acc && pslverr);
  cov_irq: cover property ($rose(irq));
endmodule // sbh_checker_sva
bind sbh_top sbh_checker_sva u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ### sbh_consts.vh
// How it works
// - a byte write sends the data register; a byte read loads the received byte into it.
// - the word index register is sent as the byte address of every full-protocol access.
// - the 7-bit target address comes from bits 7..1 of the target register.
// - bit 0 of the target register is the direction: 0 byte write, 1 byte read.
// - writing the target register launches the access and holds busy until it ends.
// - with short protocol select set, send-byte/receive-byte are used and no index is sent.
// - a missing acknowledge sets a sticky error flag that software clears by writing 1.
`ifndef SBH_CONSTS_VH
`define SBH_CONSTS_VH
// register indexes; byte address is four times the index
`define SBH_IDX_DATA 8'hb0
`define SBH_IDX_INDEX 8'hb1
`define SBH_IDX_TARGET 8'hb2
`define SBH_IDX_CTRL 8'hb3
`define SBH_IDX_INT_STAT 8'hb4
`define SBH_IDX_INT_MASK 8'hb5
// control/status fields
`define SBH_CTRL_SHORT 7
`define SBH_CTRL_BUSY 5
`define SBH_CTRL_DETECT 3
`define SBH_CTRL_TEST 2
`define SBH_CTRL_ERR 1
`define SBH_CTRL_ROMERR 0
// interrupt status fields
`define SBH_INT_DONE 0
`define SBH_INT_ERR 1
`define SBH_RESET_BYTE 8'h00
// timing: one quarter of a bus clock period
`define SBH_CLK_NS 25
`define SBH_QTR_NS 2500
`define SBH_TEST_QTR_NS 250
`define SBH_QTR_CYC (`SBH_QTR_NS / `SBH_CLK_NS)
`define SBH_TEST_QTR_CYC (`SBH_TEST_QTR_NS / `SBH_CLK_NS)
// bit commands
`define SBH_CMD_START 2'h0
`define SBH_CMD_STOP 2'h1
`define SBH_CMD_WRITE 2'h2
`define SBH_CMD_READ 2'h3
`endif

// ### sbh_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbh_target_model (
  // two-wire bus
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  // bench control
  input wire logic nack,
  input wire logic [7:0] rd_byte,
  output logic [23:0] got
);
  logic [7:0] sh = 8'h00;
  logic tx = 1'b0;
  logic pend = 1'b0;
  int bits = 0;
  int nb = 0;
  initial
  begin
    sda_pull = 1'b0;
    got = 24'h0;
  end
  // start or repeated start
  always @(negedge sda)
    if (scl)
    begin
      bits = 0;
      nb = 0;
      tx = 1'b0;
    end
  // shift in msb first on rising clock
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    bits++;
  end
  // ack bytes, then serve a read byte after address with read bit
  always @(negedge scl)
  begin
    sda_pull = 1'b0;
    if (bits == 8 && !tx)
    begin
      got = {got[15:0], sh};
      sda_pull = !nack;
      pend = !nack && nb == 0 && sh[0];
      nb++;
    end
    else if (bits == 9)
    begin
      bits = 0;
      tx = pend;
      pend = 1'b0;
    end
    if (tx && bits < 8)
      sda_pull = !rd_byte[7 - bits];
  end
endmodule // sbh_target_model
`default_nettype wire

// ### sbh_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sbh_consts.vh"
module sbh_top (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // interrupt
  output reg irq,
  // two-wire bus, open drain
  output reg scl_o,
  output wire scl_oe,
  input wire sda_i,
  output reg sda_o,
  output wire sda_oe
);
  localparam [3:0] S_IDLE = 4'd0;
  localparam [3:0] S_START1 = 4'd1;
  localparam [3:0] S_ADDR1 = 4'd2;
  localparam [3:0] S_INDEX = 4'd3;
  localparam [3:0] S_WDATA = 4'd4;
  localparam [3:0] S_START2 = 4'd5;
  localparam [3:0] S_ADDR2 = 4'd6;
  localparam [3:0] S_RDATA = 4'd7;
  localparam [3:0] S_STOP = 4'd8;
  localparam integer QTR_CYC = `SBH_QTR_CYC;
  localparam integer TEST_QTR_CYC = `SBH_TEST_QTR_CYC;
  localparam [7:0] QTR_LAST = QTR_CYC[7:0] - 8'h01;
  localparam [7:0] TEST_QTR_LAST = TEST_QTR_CYC[7:0] - 8'h01;
  reg [7:0] transfer_byte;
  reg [7:0] word_index;
  reg [7:0] target_reg;
  reg short_protocol_select;
  reg test_speed;
  reg access_error;
  reg [1:0] int_stat;
  reg [1:0] int_mask;
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg waiting;
  reg [7:0] div_cnt;
  reg tick;
  reg sda_s1;
  reg sda_s2;
  reg sda_s3;
  reg sda_level;
  reg cmd_valid;
  reg [1:0] cmd;
  reg bit_tx;
  reg [3:0] next_state;
  reg [7:0] rd_word;
  reg rd_ok;
  wire eng_busy;
  wire eng_done;
  wire eng_rx;
  wire access_in_progress = (state != S_IDLE);
  wire [6:0] target_address = target_reg[7:1];
  wire direction_bit = target_reg[0];
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  wire rd = psel && penable && pready && !pwrite;
  wire [7:0] idx = paddr[9:2];
  wire byte_state = (state == S_ADDR1) || (state == S_INDEX) || (state == S_WDATA) ||
                    (state == S_ADDR2) || (state == S_RDATA);
  wire nack_seen = eng_done && byte_state && (state != S_RDATA) && (bit_cnt == 4'd8) && eng_rx;
  wire finished = eng_done && (state == S_STOP);
  sbh_bit_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .bit_tx(bit_tx),
    .busy(eng_busy),
    .done(eng_done),
    .bit_rx(eng_rx),
    .sda_level(sda_level),
    .scl_drive(scl_oe),
    .sda_drive(sda_oe)
  );
  // quarter-period divider, faster in test mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (div_cnt >= (test_speed ? TEST_QTR_LAST : QTR_LAST))
    begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end
  // data line synchroniser; level changes once stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      sda_level <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (sda_s2 == sda_s3)
        sda_level <= sda_s3;
    end
  end
  always @*
  begin
    cmd = `SBH_CMD_WRITE;
    bit_tx = 1'b1;
    case (state)
      S_START1, S_START2: cmd = `SBH_CMD_START;
      S_STOP: cmd = `SBH_CMD_STOP;
      S_RDATA: cmd = (bit_cnt == 4'd8) ? `SBH_CMD_WRITE : `SBH_CMD_READ;
      default:
      begin
        cmd = (bit_cnt == 4'd8) ? `SBH_CMD_READ : `SBH_CMD_WRITE;
        bit_tx = shift[7];
      end
    endcase
  end
  always @*
  begin
    next_state = S_IDLE;
    case (state)
      S_START1: next_state = S_ADDR1;
      S_ADDR1:
        if (short_protocol_select)
          next_state = direction_bit ? S_RDATA : S_WDATA;
        else
          next_state = S_INDEX;
      S_INDEX: next_state = direction_bit ? S_START2 : S_WDATA;
      S_WDATA: next_state = S_STOP;
      S_START2: next_state = S_ADDR2;
      S_ADDR2: next_state = S_RDATA;
      S_RDATA: next_state = S_STOP;
      default: next_state = S_IDLE;
    endcase
  end
  // transfer sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      bit_cnt <= 4'd0;
      shift <= 8'h00;
      waiting <= 1'b0;
      cmd_valid <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (state == S_IDLE)
      begin
        if (wr && idx == `SBH_IDX_TARGET)
          state <= S_START1;
      end
      else if (!waiting && !eng_busy && !cmd_valid)
      begin
        cmd_valid <= 1'b1;
        waiting <= 1'b1;
      end
      else if (eng_done)
      begin
        waiting <= 1'b0;
        if (byte_state && bit_cnt != 4'd8)
        begin
          bit_cnt <= bit_cnt + 4'd1;
          shift <= {shift[6:0], eng_rx};
        end
        else
        begin
          bit_cnt <= 4'd0;
          state <= nack_seen ? S_STOP : next_state;
          case (next_state)
            S_ADDR1: shift <= {target_address,
                               short_protocol_select & direction_bit};
            S_INDEX: shift <= word_index;
            S_WDATA: shift <= transfer_byte;
            S_ADDR2: shift <= {target_address, 1'b1};
            default: shift <= shift;
          endcase
        end
      end
    end
  end
  // registers, error and interrupt flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transfer_byte <= `SBH_RESET_BYTE;
      word_index <= `SBH_RESET_BYTE;
      target_reg <= `SBH_RESET_BYTE;
      short_protocol_select <= 1'b0;
      test_speed <= 1'b0;
      access_error <= 1'b0;
      int_stat <= 2'b00;
      int_mask <= 2'b00;
      irq <= 1'b0;
    end
    else
    begin
      if (eng_done && state == S_RDATA && bit_cnt == 4'd8)
        transfer_byte <= shift;
      else if (wr && idx == `SBH_IDX_DATA)
        transfer_byte <= pwdata[7:0];
      if (wr && idx == `SBH_IDX_INDEX)
        word_index <= pwdata[7:0];
      if (wr && idx == `SBH_IDX_TARGET && !access_in_progress)
        target_reg <= pwdata[7:0];
      if (wr && idx == `SBH_IDX_CTRL)
      begin
        short_protocol_select <= pwdata[`SBH_CTRL_SHORT];
        test_speed <= pwdata[`SBH_CTRL_TEST];
      end
      if (nack_seen)
        access_error <= 1'b1;
      else if (wr && idx == `SBH_IDX_CTRL && pwdata[`SBH_CTRL_ERR])
        access_error <= 1'b0;
      if (wr && idx == `SBH_IDX_INT_MASK)
        int_mask <= pwdata[1:0];
      int_stat <= (int_stat & ~((rd && idx == `SBH_IDX_INT_STAT) ? prdata[1:0] : 2'b00)) |
                  {nack_seen, finished};
      irq <= |(int_stat & int_mask);
    end
  end
  // read mux
  always @*
  begin
    rd_word = 8'h00;
    rd_ok = 1'b1;
    case (idx)
      `SBH_IDX_DATA: rd_word = transfer_byte;
      `SBH_IDX_INDEX: rd_word = word_index;
      `SBH_IDX_TARGET: rd_word = target_reg;
      `SBH_IDX_CTRL:
      begin
        rd_word[`SBH_CTRL_SHORT] = short_protocol_select;
        rd_word[`SBH_CTRL_BUSY] = access_in_progress;
        rd_word[`SBH_CTRL_TEST] = test_speed;
        rd_word[`SBH_CTRL_ERR] = access_error;
      end
      `SBH_IDX_INT_STAT: rd_word = {6'b00_0000, int_stat};
      `SBH_IDX_INT_MASK: rd_word = {6'b00_0000, int_mask};
      default: rd_ok = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00)
      rd_ok = 1'b0;
  end
  // apb answer, registered in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_word};
      pready <= 1'b1;
      pslverr <= ~rd_ok;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // sbh_top
`default_nettype wire

// ### test_sbh_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbh_top;
  localparam logic [11:0] DAT = 12'h2c0, IDX = 12'h2c4, TGT = 12'h2c8;
  localparam logic [11:0] CTL = 12'h2cc, STA = 12'h2d0, MSK = 12'h2d4;
  logic pclk, presetn, psel, penable, pwrite, nack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [7:0] rd_byte;
  wire logic [31:0] prdata;
  wire logic [23:0] got;
  wire logic pready, pslverr, irq, scl_oe, sda_oe, pull;
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || pull);
  int fail_count, num_checks;
  sbh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  sbh_target_model peer (.scl(scl), .sda(sda), .sda_pull(pull), .nack(nack),
    .rd_byte(rd_byte), .got(got));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = !pclk;
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // access phase holds until pready is sampled high
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic idle();
    int n;
    n = 0;
    apb(1'b0, CTL, 8'h00);
    while (q[5] !== 1'b0 && n < 9000)
    begin
      apb(1'b0, CTL, 8'h00);
      n++;
    end
    chk("busy", 32'h0, 32'(q[5]));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    fail_count++;
    results();
  end
  initial
  begin
    presetn <= 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nack = 1'b0;
    rd_byte = 8'h5a;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(DAT + 12'(4 * i), 32'h0, "reset");
    apb(1'b0, 12'h2e0, 8'h00);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'b1, CTL, 8'h04);
    apb(1'b1, MSK, 8'h03);
    repeat (600) @(posedge pclk);
    $display("registers done");
    apb(1'b1, DAT, 8'ha5);
    apb(1'b1, IDX, 8'h3c);
    apb(1'b1, TGT, 8'ha0);
    rd(CTL, 32'h24, "busy set");
    idle();
    chk("write", 32'h00a0_3ca5, 32'(got));
    chk("irq", 32'h1, 32'(irq));
    rd(STA, 32'h1, "done");
    apb(1'b1, TGT, 8'ha1);
    idle();
    chk("read", 32'h00a0_3ca1, 32'(got));
    rd(DAT, 32'h5a, "rdata");
    $display("full done");
    apb(1'b1, MSK, 8'h00);
    apb(1'b1, CTL, 8'h84);
    apb(1'b1, DAT, 8'h69);
    apb(1'b1, TGT, 8'ha0);
    idle();
    chk("short write", 32'h00a1_a069, 32'(got));
    chk("masked", 32'h0, 32'(irq));
    rd(STA, 32'h1, "done2");
    rd_byte <= 8'hc3;
    apb(1'b1, TGT, 8'ha1);
    idle();
    chk("short read", 32'h00a0_69a1, 32'(got));
    rd(DAT, 32'hc3, "rdata2");
    $display("short done");
    nack <= 1'b1;
    apb(1'b1, CTL, 8'h04);
    apb(1'b1, TGT, 8'ha0);
    idle();
    rd(CTL, 32'h06, "error");
    apb(1'b0, STA, 8'h00);
    chk("err int", 32'h1, 32'(q[1]));
    apb(1'b1, CTL, 8'h06);
    rd(CTL, 32'h04, "w1c");
    $display("error done");
    nack <= 1'b0;
    apb(1'b1, CTL, 8'h80);
    apb(1'b1, DAT, 8'h96);
    apb(1'b1, TGT, 8'ha0);
    repeat (1000) @(posedge pclk);
    rd(CTL, 32'h0000_00a0, "slow busy");
    idle();
    chk("slow write", 32'h00a0_a096, 32'(got));
    $display("speed done");
    results();
  end
endmodule // test_sbh_top
`default_nettype wire
